// ---- dv/hsc_chk.sv ----
/* Port checker for the halt and standby controller.
   Assumes one clock and a bind onto hsc_halt_standby_control. */
module hsc_chk (
  input wire logic clk_i,           // Clock
  input wire logic sys_rst_i,       // Reset
  input wire logic halt_exec_i,     // Halt executed
  input wire logic irq_valid_i,     // Wake request
  input wire logic bus_release_i,   // Bus given away
  input wire logic svc_valid_o,     // Offer to core
  input wire logic halted_o,        // Core halted
  input wire logic stop_o,          // Stop signal
  input wire logic sys_clk_en_o,    // System clock on
  input wire logic periph_clk_en_o, // Peripheral clock on
  input wire logic watchdog_en_o,   // Watchdog on
  input wire logic state_tick_o     // State pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ****************
  // Properties
  // ****************
  property p_tick; !$past(sys_rst_i) |-> state_tick_o != $past(state_tick_o); endproperty
  property p_stop; stop_o |-> halted_o && !sys_clk_en_o && !periph_clk_en_o; endproperty
  property p_entry; (halt_exec_i && !halted_o) ##1 (!irq_valid_i)[*3] |=> halted_o; endproperty
  property p_release; halted_o && sys_clk_en_o && irq_valid_i |=> !halted_o; endproperty
  property p_warm; halted_o && irq_valid_i |-> ##[1:1000] !halted_o; endproperty
  property p_resume; $rose(sys_clk_en_o) |-> !halted_o && !stop_o; endproperty
  property p_wd; $fell(sys_rst_i) |-> watchdog_en_o; endproperty
  property p_brel; bus_release_i && !halted_o |-> periph_clk_en_o; endproperty
  property p_svc; svc_valid_o |-> !halted_o && sys_clk_en_o; endproperty
  a_tick: assert property (p_tick) else $error("state pulse not alternating");
  a_stop: assert property (p_stop) else $error("stop without halted clocks");
  a_entry: assert property (p_entry) else $error("halt not reached after entry");
  a_release: assert property (p_release) else $error("halt not released");
  a_warm: assert property (p_warm) else $error("warm-up never ended");
  a_resume: assert property (p_resume) else $error("clock back while halted");
  a_wd: assert property (p_wd) else $error("watchdog off after reset");
  a_brel: assert property (p_brel) else $error("peripherals stopped on release");
  a_svc: assert property (p_svc) else $error("offer while halted");
  c_warm: cover property (halted_o && irq_valid_i && !sys_clk_en_o);
  c_stop: cover property ($rose(stop_o));
  c_svc: cover property (svc_valid_o && bus_release_i);
endmodule

bind hsc_halt_standby_control hsc_chk u_chk (.clk_i, .sys_rst_i, .halt_exec_i, .irq_valid_i,
  .bus_release_i, .svc_valid_o, .halted_o, .stop_o, .sys_clk_en_o, .periph_clk_en_o,
  .watchdog_en_o, .state_tick_o);

// ---- dv/hsc_core_model.sv ----
/* Core model: takes offered wake requests, optionally stalling.
   Assumes the controller's offer handshake on the same clock. */
module hsc_core_model (
  input  wire logic       clk_i,       // Clock
  input  wire logic       sys_rst_i,   // Reset
  input  wire logic       slow_i,      // Stall some cycles
  input  wire logic       svc_valid_i, // Offer
  input  wire logic [2:0] svc_prio_i,  // Offered priority
  output logic            svc_ready_o, // Accept
  output logic            got_o,       // Request taken, pulse
  output logic      [2:0] got_prio_o   // Taken priority
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg     <= 2'h0;
      svc_ready_o <= 1'b0;
      got_o       <= 1'b0;
    end else begin
      cnt_reg     <= cnt_reg + 2'h1;
      svc_ready_o <= !slow_i || cnt_reg[1];
      got_o       <= svc_valid_i && svc_ready_o;
      got_prio_o  <= svc_prio_i;
    end
  end
endmodule

// ---- dv/hsc_halt_standby_control_tb.sv ----
/* Self-checking bench for the halt and standby controller.
   Assumes hsc_pkg, the checker bind and the core model are compiled first. */
module hsc_halt_standby_control_tb
  import hsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, hsel, hwrite, halt_exec, irq_valid, bus_rel;
  logic        slow, hready, hresp, svc_valid, svc_ready, halted, stop, sclk, pclk, wd, tick;
  logic        got;
  logic [31:0] haddr, hwdata, hrdata, rd, rv, seed = 32'h30;
  logic [1:0]  htrans;
  logic [2:0]  irq_prio, svc_prio, got_prio, p1, p2;
  logic [2:0]  exp_q[$];
  int          err_count = 0, num_checks = 0;
  int          nw;
  always #20 clk_i = ~clk_i;
  hsc_halt_standby_control dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .halt_exec_i(halt_exec), .irq_valid_i(irq_valid), .irq_prio_i(irq_prio),
    .bus_release_i(bus_rel), .svc_ready_i(svc_ready), .svc_valid_o(svc_valid),
    .svc_prio_o(svc_prio), .halted_o(halted), .stop_o(stop), .sys_clk_en_o(sclk),
    .periph_clk_en_o(pclk), .watchdog_en_o(wd), .state_tick_o(tick));
  hsc_core_model core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
    .svc_valid_i(svc_valid), .svc_prio_i(svc_prio), .svc_ready_o(svc_ready),
    .got_o(got), .got_prio_o(got_prio));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chb(input string n, input logic e, input logic g);
    chk(n, 32'(e), 32'(g));
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_i);
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsel   <= 1'b1;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Optional request in the entry window, then stop where halt should have landed
  task automatic halt_go(input logic win, input logic [2:0] p);
    @(posedge clk_i);
    halt_exec <= 1'b1;
    @(posedge clk_i);
    halt_exec <= 1'b0;
    irq_valid <= win;
    irq_prio  <= p;
    @(posedge clk_i);
    irq_valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic wake(input logic [2:0] p, output int n);
    @(posedge clk_i);
    irq_valid <= 1'b1;
    irq_prio  <= p;
    @(posedge clk_i);
    irq_valid <= 1'b0;
    n = 0;
    while (halted !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    #1;
    chb("woke", 1'b0, halted);
  endtask
  // Taken requests are matched in service order
  always @(posedge clk_i) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk("extra service", 32'h0, 32'h1);
      else chk("service prio", 32'(exp_q.pop_front()), 32'(got_prio));
    end
  end
  initial begin
    {hsel, hwrite, halt_exec, irq_valid, bus_rel, slow} = '0;
    {haddr, hwdata, htrans, irq_prio} = '0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl", {27'h0, XOSC_RESET, KEEP_RESET, MODE_RESET, WD_EN_RESET}, rd);
    chb("resp", 1'b0, hresp);
    bus(1'b0, WARM_OFFSET, 32'h0, rd);
    chk("warm", 32'(WARM_RESET), rd);
    bus(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, STAT_OFFSET, 32'h0, rd);
    chk("stat", (32'h1 << STAT_SCLK_BIT) | (32'h1 << STAT_PCLK_BIT), rd);
    bus(1'b1, WARM_OFFSET, 32'h1, rd);
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 4; m++) begin
        rv = xs();
        slow <= rv[0];
        // Second pass also runs without the external oscillator
        bus(1'b1, CTRL_OFFSET, {27'h0, ~k[0], k[0], m[1:0], 1'b1}, rd);
        halt_go(1'b0, 3'h0);
        chb("halted", 1'b1, halted);
        chb("stop", m == 1 && k == 0, stop);
        chb("sys clk", !(m == 1 || m == 2), sclk);
        chb("periph clk", !(m == 1 || m == 2), pclk);
        exp_q.push_back(rv[3:1]);
        wake(rv[3:1], nw);
        chb("warm wait", m == 1 && k == 0, nw > 2);
        chb("awake clk", 1'b1, sclk);
        chb("awake stop", 1'b0, stop);
      end
    end
    bus_rel <= 1'b1;
    // Light idle and stop hold the window request; run and peripheral idle abort
    for (int m = 0; m < 4; m++) begin
      rv = xs();
      p1 = rv[3:1];
      p2 = rv[6:4];
      bus(1'b1, CTRL_OFFSET, {27'h0, 1'b1, 1'b0, m[1:0], 1'b1}, rd);
      // An aborted entry is serviced before halt_go returns
      if (m == 0 || m == 3) exp_q.push_back(p1);
      halt_go(1'b1, p1);
      chb("window halt", m == 1 || m == 2, halted);
      if (m == 1 || m == 2) begin
        exp_q.push_back(p1 >= p2 ? p1 : p2);
        exp_q.push_back(p1 >= p2 ? p2 : p1);
        wake(p2, nw);
      end
      repeat (10) @(posedge clk_i);
      chb("periph on", 1'b1, pclk);
    end
    bus(1'b0, STAT_OFFSET, 32'h0, rd);
    chb("bus release", 1'b1, rd[STAT_BREL_BIT]);
    chb("wd on", 1'b1, wd);
    bus(1'b1, CTRL_OFFSET, 32'h10, rd);
    #1;
    chb("wd off", 1'b0, wd);
    repeat (30) @(posedge clk_i);
    chk("queue left", 32'h0, 32'(exp_q.size()));
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule

// ---- rtl/hsc_halt_standby_control.sv ----
/*
 * Halt and standby controller: stop signal, warm-up before the system
 * clock resumes, held-back wake requests during halt entry and ordered
 * release of pending requests to the core, plus watchdog enable.
 * Assumes the core and interrupt controller run on clk_i, and one
 * AHB-Lite master reaches the registers.
 */
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
// Contract
// - Stop setting plus executed halt instruction drives the internal stop signal high.
// - Drive keep enable set holds the stop signal low regardless.
// - One state equals two oscillator cycles.
// - Stop release with external oscillator runs warm-up before system clock resumes.
// - Watchdog is enabled out of reset; software disables it explicitly.
// - Peripherals and watchdog keep running while the bus is released.
// - Wake request in last 3 entry clocks of light idle or stop is held pending.
// - Run and peripheral idle settings have no missed-wake window.
// - Later interrupt releases halt; higher priority of both is serviced first.
// - Outside the entry window an interrupt releases any halt setting.
module hsc_halt_standby_control
  import hsc_pkg::*;
(
  input  wire logic        clk_i,         // 25 MHz high speed clock
  input  wire logic        sys_rst_i,     // Synchronous reset, active high
  // AHB-Lite slave
  input  wire logic        hsel_i,        // Slave select
  input  wire logic [31:0] haddr_i,       // Byte address
  input  wire logic [1:0]  htrans_i,      // Transfer type
  input  wire logic        hwrite_i,      // Write when high
  input  wire logic [2:0]  hsize_i,       // Transfer size (word only)
  input  wire logic        hready_i,      // Bus ready
  input  wire logic [31:0] hwdata_i,      // Write data
  output logic      [31:0] hrdata_o,      // Read data
  output logic             hreadyout_o,   // Slave ready
  output logic             hresp_o,       // Always OKAY
  // Core and interrupt controller
  input  wire logic        halt_exec_i,   // Halt instruction executed, pulse
  input  wire logic        irq_valid_i,   // Wake capable request, pulse
  input  wire logic [2:0]  irq_prio_i,    // Priority of request
  input  wire logic        bus_release_i, // External bus granted away
  input  wire logic        svc_ready_i,   // Core takes the offered request
  output logic             svc_valid_o,   // Request offered to core
  output logic      [2:0]  svc_prio_o,    // Priority of offered request
  output logic             halted_o,      // Core held in halt
  output logic             stop_o,        // Internal stop signal
  output logic             sys_clk_en_o,  // System clock enable
  output logic             periph_clk_en_o, // Peripheral block clock enable
  output logic             watchdog_en_o, // Watchdog enable
  output logic             state_tick_o   // One pulse per state
);

  // ********************************************************
  // Registers
  // ********************************************************
  hsc_state_type       state_reg;
  hsc_state_type       state_next;
  hsc_mode_type        mode_reg;
  logic                wd_en_reg;
  logic                keep_reg;
  logic                xosc_reg;
  logic [15:0]         warm_len_reg;
  logic [15:0]         warm_cnt_reg;
  logic [1:0]          entry_cnt_reg;
  logic                tick_reg;
  logic                stop_reg;
  logic                sclk_reg;
  logic                pclk_reg;
  logic                pend_v_reg;
  logic [2:0]          pend_p_reg;
  logic                new_v_reg;
  logic [2:0]          new_p_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic [31:0]         rdata_reg;

  logic                window_hold;
  logic                svc_take;
  logic                pick_pend;
  logic                ahb_req;
  logic [31:0]         stat_word;

  // ********************************************************
  // State strobe
  // ********************************************************
  // A state is two oscillator cycles; the strobe marks its end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
    end
  end

  assign state_tick_o = tick_reg;

  // ********************************************************
  // Halt sequencer
  // ********************************************************
  // Light idle and stop close the wake path before entry completes
  assign window_hold = (mode_reg == HSC_MODE_STOP) || (mode_reg == HSC_MODE_LIGHT);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HSC_ST_RUN: begin
        if (halt_exec_i) begin
          state_next = HSC_ST_ENTER;
        end
      end
      HSC_ST_ENTER: begin
        if (irq_valid_i && !window_hold) begin
          state_next = HSC_ST_RUN;
        end else if (entry_cnt_reg == 2'h0) begin
          state_next = HSC_ST_HALT;
        end
      end
      HSC_ST_HALT: begin
        if (irq_valid_i) begin
          if (mode_reg == HSC_MODE_STOP && xosc_reg) begin
            state_next = HSC_ST_WARM;
          end else begin
            state_next = HSC_ST_RUN;
          end
        end
      end
      HSC_ST_WARM: begin
        if (warm_cnt_reg == 16'h0000 && tick_reg) begin
          state_next = HSC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= HSC_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      entry_cnt_reg <= 2'h0;
    end else if (state_reg == HSC_ST_RUN) begin
      entry_cnt_reg <= ENTRY_CNT_LOAD;
    end else if (state_reg == HSC_ST_ENTER && entry_cnt_reg != 2'h0) begin
      entry_cnt_reg <= entry_cnt_reg - 2'h1;
    end
  end

  // Warm-up counts whole states, so its length is in units of two clocks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      warm_cnt_reg <= 16'h0000;
    end else if (state_reg != HSC_ST_WARM) begin
      warm_cnt_reg <= warm_len_reg;
    end else if (tick_reg && warm_cnt_reg != 16'h0000) begin
      warm_cnt_reg <= warm_cnt_reg - 16'h0001;
    end
  end

  // ********************************************************
  // Clock and stop outputs
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= (state_next == HSC_ST_HALT) && (mode_reg == HSC_MODE_STOP)
                  && !keep_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_reg <= 1'b1;
    end else begin
      sclk_reg <= !(state_next == HSC_ST_WARM) &&
                  !((state_next == HSC_ST_HALT) && window_hold);
    end
  end

  // Bus release deliberately does not gate the peripheral block
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pclk_reg <= 1'b1;
    end else begin
      pclk_reg <= !(state_next == HSC_ST_WARM) &&
                  !((state_next == HSC_ST_HALT) && window_hold);
    end
  end

  assign stop_o          = stop_reg;
  assign sys_clk_en_o    = sclk_reg;
  assign periph_clk_en_o = pclk_reg;
  assign watchdog_en_o   = wd_en_reg;
  assign halted_o        = (state_reg == HSC_ST_HALT) || (state_reg == HSC_ST_WARM);

  // ********************************************************
  // Held and new wake requests
  // ********************************************************
  // Two slots: one held during entry, one that ends the halt
  assign pick_pend   = pend_v_reg && (!new_v_reg || pend_p_reg >= new_p_reg);
  assign svc_valid_o = (state_reg == HSC_ST_RUN) && (pend_v_reg || new_v_reg);
  assign svc_prio_o  = pick_pend ? pend_p_reg : new_p_reg;
  assign svc_take    = svc_valid_o && svc_ready_i;

  // Capture takes priority over a same-cycle service clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_v_reg <= 1'b0;
      pend_p_reg <= 3'h0;
    end else if (irq_valid_i && state_reg == HSC_ST_ENTER && window_hold) begin
      pend_v_reg <= 1'b1;
      pend_p_reg <= irq_prio_i;
    end else if (svc_take && pick_pend) begin
      pend_v_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      new_v_reg <= 1'b0;
      new_p_reg <= 3'h0;
    end else if (irq_valid_i && (state_reg == HSC_ST_HALT ||
                 (state_reg == HSC_ST_ENTER && !window_hold))) begin
      new_v_reg <= 1'b1;
      new_p_reg <= irq_prio_i;
    end else if (svc_take && !pick_pend) begin
      new_v_reg <= 1'b0;
    end
  end

  // ********************************************************
  // AHB-Lite slave
  // ********************************************************
  // Zero wait states; read data is captured in the address phase
  assign ahb_req     = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_reg;

  always_comb begin
    stat_word                           = 32'h0000_0000;
    stat_word[1:0]                      = state_reg;
    stat_word[STAT_STOP_BIT]            = stop_reg;
    stat_word[STAT_SCLK_BIT]            = sclk_reg;
    stat_word[STAT_PCLK_BIT]            = pclk_reg;
    stat_word[STAT_PEND_BIT]            = pend_v_reg;
    stat_word[STAT_PPRI_LSB +: 3]       = pend_p_reg;
    stat_word[STAT_NEW_BIT]             = new_v_reg;
    stat_word[STAT_NPRI_LSB +: 3]       = new_p_reg;
    stat_word[STAT_BREL_BIT]            = bus_release_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ahb_req && hwrite_i && hsize_i == 3'h2;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ahb_req && !hwrite_i && haddr_i[31:8] == 24'h00_0000) begin
      unique case (haddr_i[7:0])
        CTRL_OFFSET: rdata_reg <= {27'h0, xosc_reg, keep_reg, mode_reg, wd_en_reg};
        WARM_OFFSET: rdata_reg <= {16'h0000, warm_len_reg};
        STAT_OFFSET: rdata_reg <= stat_word;
        default:     rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wd_en_reg <= WD_EN_RESET;
      mode_reg  <= MODE_RESET;
      keep_reg  <= KEEP_RESET;
      xosc_reg  <= XOSC_RESET;
    end else if (wr_pend_reg && wr_addr_reg == CTRL_OFFSET) begin
      wd_en_reg <= hwdata_i[CTRL_WD_EN_BIT];
      mode_reg  <= hsc_mode_type'(hwdata_i[CTRL_MODE_LSB +: 2]);
      keep_reg  <= hwdata_i[CTRL_KEEP_BIT];
      xosc_reg  <= hwdata_i[CTRL_XOSC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      warm_len_reg <= WARM_RESET;
    end else if (wr_pend_reg && wr_addr_reg == WARM_OFFSET) begin
      warm_len_reg <= hwdata_i[WARM_WIDTH-1:0];
    end
  end

endmodule

// ---- rtl/hsc_pkg.sv ----
/*
 * Shared constants for the halt and standby controller: register map,
 * field positions, reset values, halt settings and timing counts.
 * Assumes a single 25 MHz clock and an AHB-Lite register bus.
 */
package hsc_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          OSC_PER_STATE   = 2;
  localparam int          ENTRY_CLOCKS    = 3;
  localparam logic [1:0]  ENTRY_CNT_LOAD  = 2'(ENTRY_CLOCKS - 1);

  // ********************************************************
  // Register offsets (byte addresses)
  // ********************************************************
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  WARM_OFFSET     = 8'h04;
  localparam logic [7:0]  STAT_OFFSET     = 8'h08;

  // ********************************************************
  // Control register fields and reset values
  // ********************************************************
  localparam int          CTRL_WD_EN_BIT  = 0;
  localparam int          CTRL_MODE_LSB   = 1;
  localparam int          CTRL_KEEP_BIT   = 3;
  localparam int          CTRL_XOSC_BIT   = 4;
  localparam logic        WD_EN_RESET     = 1'b1;
  localparam logic        KEEP_RESET      = 1'b0;
  localparam logic        XOSC_RESET      = 1'b1;
  localparam int          WARM_WIDTH      = 16;
  localparam logic [15:0] WARM_RESET      = 16'h0100;

  // ********************************************************
  // Status register fields
  // ********************************************************
  localparam int          STAT_STOP_BIT   = 2;
  localparam int          STAT_SCLK_BIT   = 3;
  localparam int          STAT_PCLK_BIT   = 4;
  localparam int          STAT_PEND_BIT   = 5;
  localparam int          STAT_PPRI_LSB   = 6;
  localparam int          STAT_NEW_BIT    = 9;
  localparam int          STAT_NPRI_LSB   = 10;
  localparam int          STAT_BREL_BIT   = 13;

  // ********************************************************
  // Halt settings and controller states
  // ********************************************************
  typedef enum logic [1:0] {
    HSC_MODE_RUN   = 2'h0,
    HSC_MODE_STOP  = 2'h1,
    HSC_MODE_LIGHT = 2'h2,
    HSC_MODE_PERIPH = 2'h3
  } hsc_mode_type;

  localparam hsc_mode_type MODE_RESET = HSC_MODE_RUN;

  typedef enum logic [1:0] {
    HSC_ST_RUN   = 2'b00,
    HSC_ST_ENTER = 2'b01,
    HSC_ST_HALT  = 2'b11,
    HSC_ST_WARM  = 2'b10
  } hsc_state_type;

  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

endpackage
